/* design/cmpr_ctrl.sv */
// Comparator change events, interrupt gating and reference control registers
// Overview of operation
// - A comparator output change sets its change flag, bits 4 and 3.
// - Writing one to a change flag sets it like a real change.
// - Interrupt asserts only with flag, comparator, peripheral and global enables set.
// - Flags still set on changes while any interrupt enable is clear.
// - Flag is set on the mismatch rising edge, not its level.
// - Without latch refresh, returning to the earlier output sets no flag.
// - Control register read or write refreshes the latch; a return then sets flag.
// - Change coinciding with a read may lose its flag; here it is kept.
// - Reset returns all registers to reset values, both comparators disabled.
// - Ladder takes 4-bit level code and range bit; one is low range.
// - All ladder enables clear, code zero, low range gives ground output.
// - Bits 7 and 6 select ladder when set, fixed reference when clear.
// - Ladder powers down when both ladder selects and ladder pin enable are low.
// - Bit 5 of fixed reference control reads the bandgap stable flag.
// - Bit 4 set bypasses and powers down the pin buffer.
// - Bit 3 enables fixed reference; forced high on high-voltage variant.
// - Bit 1 set routes ladder to pin, ignoring bit 2; else bit 2 routes.
// - Reading the mirror register leaves the mismatch latches unchanged.
// - Comparator outputs are latched every cycle; detection compares latched values.
`timescale 1ns/1ps
`default_nettype none

`include "cmpr_cfg.svh"

module cmpr_ctrl
	import cmpr_pkg::*;
#(
	parameter int HV_VARIANT = 0
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Register port
	input wire logic [`CMPR_ADDR_W-1:0] addr_in,
	input wire logic [`CMPR_DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [`CMPR_DATA_W-1:0] rdata_out,
	// Analog comparator raw outputs and bandgap status
	input wire logic cmp_one_raw_in,
	input wire logic cmp_two_raw_in,
	input wire logic bandgap_stable_flag_in,
	// Comparator controls
	output logic [`CMPR_DATA_W-1:0] cmp_one_config_out,
	output logic [`CMPR_DATA_W-1:0] cmp_two_config_out,
	output logic [`CMPR_DATA_W-1:0] mirror_config_out,
	// Interrupt request
	output logic irq_out,
	// Ladder controls
	output logic [3:0] ladder_level_code_out,
	output logic ladder_range_select_out,
	output logic cmp_one_ladder_select_out,
	output logic cmp_two_ladder_select_out,
	output logic ladder_power_down_out,
	output logic ladder_ground_out,
	// Fixed reference and pin routing
	output logic fixed_ref_enable_out,
	output logic pin_buffer_bypass_out,
	output logic pin_carries_ladder_out,
	output logic pin_carries_fixed_out
);

	if (HV_VARIANT != 0 && HV_VARIANT != 1) begin : g_bad_variant
		$error("HV_VARIANT must be 0 or 1");
	end

	////////////////////////////////////////////////////////////////////////
	cmpr_state_t cur;
	cmpr_state_t next_cur;

	logic cmp_one_output;
	logic cmp_two_output;
	logic cmp_one_latched;
	logic cmp_two_latched;
	logic cmp_one_set;
	logic cmp_two_set;
	logic refresh_one;
	logic refresh_two;
	logic wr_flags;
	logic cmp_one_pending;
	logic cmp_two_pending;
	logic fixed_enable_bit;
	logic [7:0] fixed_view;

	// A disabled comparator reads zero; polarity is applied before the latch
	assign cmp_one_output = cur.cmp_one[`CMPR_CTL_ON_BIT] &
		(cmp_one_raw_in ^ cur.cmp_one[`CMPR_CTL_POL_BIT]);
	assign cmp_two_output = cur.cmp_two[`CMPR_CTL_ON_BIT] &
		(cmp_two_raw_in ^ cur.cmp_two[`CMPR_CTL_POL_BIT]);

	// Only the individual control registers refresh; the mirror is left out
	assign refresh_one = (wr_in || rd_in) && addr_in == `CMPR_OFS_CMP_ONE;
	assign refresh_two = (wr_in || rd_in) && addr_in == `CMPR_OFS_CMP_TWO;

	cmpr_edge_det u_edge_one (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.cmp_output_in(cmp_one_output),
		.refresh_in(refresh_one),
		.latched_out(cmp_one_latched),
		.change_set_out(cmp_one_set)
	);

	cmpr_edge_det u_edge_two (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.cmp_output_in(cmp_two_output),
		.refresh_in(refresh_two),
		.latched_out(cmp_two_latched),
		.change_set_out(cmp_two_set)
	);

	assign wr_flags = wr_in && addr_in == `CMPR_OFS_FLAGS;

	// The high-voltage variant keeps the fixed reference on regardless of software
	assign fixed_enable_bit = (HV_VARIANT == 1) ? 1'b1 : cur.fixed[`CMPR_FIX_ENABLE_BIT];

	always_comb begin
		fixed_view = cur.fixed;
		fixed_view[`CMPR_FIX_ENABLE_BIT] = fixed_enable_bit;
		fixed_view[`CMPR_FIX_STABLE_BIT] = bandgap_stable_flag_in;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_cur = cur;
		next_cur.rdata = `CMPR_RST_ZERO;
		if (wr_in) begin
			unique case (addr_in)
				`CMPR_OFS_FLAGS: next_cur.flags = wdata_in;
				`CMPR_OFS_ENABLES: next_cur.enables = wdata_in;
				`CMPR_OFS_CMP_ONE: next_cur.cmp_one = wdata_in & `CMPR_WMASK_CMP;
				`CMPR_OFS_CMP_TWO: next_cur.cmp_two = wdata_in & `CMPR_WMASK_CMP;
				`CMPR_OFS_MIRROR: next_cur.mirror = wdata_in & `CMPR_WMASK_MIRROR;
				`CMPR_OFS_LADDER: next_cur.ladder = wdata_in & `CMPR_WMASK_LADDER;
				`CMPR_OFS_FIXED: next_cur.fixed = wdata_in & `CMPR_WMASK_FIXED;
				`CMPR_OFS_IRQ_CTL: next_cur.irq_ctl = wdata_in & `CMPR_WMASK_IRQ_CTL;
				default: ;
			endcase
		end
		// Hardware set wins over a same-cycle clear, so a read or write never loses an event
		if (cmp_one_set) begin
			next_cur.flags[`CMPR_FLAG_ONE_BIT] = 1'b1;
		end
		if (cmp_two_set) begin
			next_cur.flags[`CMPR_FLAG_TWO_BIT] = 1'b1;
		end
		if (rd_in) begin
			unique case (addr_in)
				`CMPR_OFS_FLAGS: next_cur.rdata = cur.flags;
				`CMPR_OFS_ENABLES: next_cur.rdata = cur.enables;
				`CMPR_OFS_CMP_ONE: begin
					next_cur.rdata = cur.cmp_one;
					next_cur.rdata[`CMPR_CTL_OUT_BIT] = cmp_one_latched;
				end
				`CMPR_OFS_CMP_TWO: begin
					next_cur.rdata = cur.cmp_two;
					next_cur.rdata[`CMPR_CTL_OUT_BIT] = cmp_two_latched;
				end
				`CMPR_OFS_MIRROR: begin
					next_cur.rdata = cur.mirror;
					next_cur.rdata[`CMPR_MIR_ONE_BIT] = cmp_one_latched;
					next_cur.rdata[`CMPR_MIR_TWO_BIT] = cmp_two_latched;
				end
				`CMPR_OFS_LADDER: next_cur.rdata = cur.ladder;
				`CMPR_OFS_FIXED: next_cur.rdata = fixed_view;
				`CMPR_OFS_IRQ_CTL: next_cur.rdata = cur.irq_ctl;
				default: next_cur.rdata = `CMPR_RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cur.flags <= `CMPR_RST_ZERO;
			cur.enables <= `CMPR_RST_ZERO;
			cur.cmp_one <= `CMPR_RST_ZERO;
			cur.cmp_two <= `CMPR_RST_ZERO;
			cur.mirror <= `CMPR_RST_MIRROR;
			cur.ladder <= `CMPR_RST_ZERO;
			cur.fixed <= `CMPR_RST_ZERO;
			cur.irq_ctl <= `CMPR_RST_ZERO;
			cur.rdata <= `CMPR_RST_ZERO;
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign rdata_out = cur.rdata;

	always_comb begin
		cmp_one_config_out = cur.cmp_one;
		cmp_one_config_out[`CMPR_CTL_OUT_BIT] = cmp_one_latched;
		cmp_two_config_out = cur.cmp_two;
		cmp_two_config_out[`CMPR_CTL_OUT_BIT] = cmp_two_latched;
		mirror_config_out = cur.mirror;
	end

	assign cmp_one_pending = cur.flags[`CMPR_FLAG_ONE_BIT] && cur.enables[`CMPR_FLAG_ONE_BIT];
	assign cmp_two_pending = cur.flags[`CMPR_FLAG_TWO_BIT] && cur.enables[`CMPR_FLAG_TWO_BIT];
	assign irq_out = (cmp_one_pending || cmp_two_pending) &&
		cur.irq_ctl[`CMPR_IC_PERIPH_BIT] && cur.irq_ctl[`CMPR_IC_GLOBAL_BIT];

	assign ladder_level_code_out = cur.ladder[3:0];
	assign ladder_range_select_out = cur.ladder[`CMPR_LAD_RANGE_BIT];
	assign cmp_one_ladder_select_out = cur.ladder[`CMPR_LAD_ONE_SEL_BIT];
	assign cmp_two_ladder_select_out = cur.ladder[`CMPR_LAD_TWO_SEL_BIT];
	assign ladder_power_down_out = !cur.ladder[`CMPR_LAD_ONE_SEL_BIT] &&
		!cur.ladder[`CMPR_LAD_TWO_SEL_BIT] && !cur.fixed[`CMPR_FIX_LADDER_OE_BIT];
	// Ground output lets comparators find zero crossings with no ladder current
	assign ladder_ground_out = ladder_power_down_out && cur.ladder[3:0] == 4'h0 &&
		cur.ladder[`CMPR_LAD_RANGE_BIT];

	assign fixed_ref_enable_out = fixed_enable_bit;
	assign pin_buffer_bypass_out = cur.fixed[`CMPR_FIX_BYPASS_BIT];
	assign pin_carries_ladder_out = cur.fixed[`CMPR_FIX_LADDER_OE_BIT];
	assign pin_carries_fixed_out = !cur.fixed[`CMPR_FIX_LADDER_OE_BIT] &&
		cur.fixed[`CMPR_FIX_PIN_OE_BIT];

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_flag_one_clear_write;
		wr_flags && !wdata_in[`CMPR_FLAG_ONE_BIT];
	endsequence

	sequence s_flag_one_set_write;
		wr_flags && wdata_in[`CMPR_FLAG_ONE_BIT];
	endsequence

	property p_change_sets_flag;
		cmp_one_set |=> cur.flags[`CMPR_FLAG_ONE_BIT];
	endproperty
	a_change_sets_flag: assert property (p_change_sets_flag) else $error("change did not set flag");

	property p_flag_holds;
		cur.flags[`CMPR_FLAG_TWO_BIT] && !wr_flags |=> cur.flags[`CMPR_FLAG_TWO_BIT];
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("flag cleared by hardware");

	property p_soft_set;
		s_flag_one_set_write |=> cur.flags[`CMPR_FLAG_ONE_BIT] ##1 cur.flags[`CMPR_FLAG_ONE_BIT] || wr_flags;
	endproperty
	a_soft_set: assert property (p_soft_set) else $error("software set lost");

	property p_irq_gating;
		irq_out |-> cur.irq_ctl[`CMPR_IC_GLOBAL_BIT] && cur.irq_ctl[`CMPR_IC_PERIPH_BIT] &&
			(cur.flags[`CMPR_FLAG_ONE_BIT] && cur.enables[`CMPR_FLAG_ONE_BIT] ||
			cur.flags[`CMPR_FLAG_TWO_BIT] && cur.enables[`CMPR_FLAG_TWO_BIT]);
	endproperty
	a_irq_gating: assert property (p_irq_gating) else $error("interrupt without all enables");

	property p_set_while_masked;
		cmp_two_set && !cur.irq_ctl[`CMPR_IC_GLOBAL_BIT] && !(wr_in && addr_in == `CMPR_OFS_IRQ_CTL) |=>
			cur.flags[`CMPR_FLAG_TWO_BIT] && !irq_out;
	endproperty
	a_set_while_masked: assert property (p_set_while_masked) else $error("masked change lost");

	property p_clear_sticks;
		s_flag_one_clear_write and !cmp_one_set |=> !cur.flags[`CMPR_FLAG_ONE_BIT];
	endproperty
	a_clear_sticks: assert property (p_clear_sticks) else $error("clear did not take");

	property p_ladder_power;
		ladder_power_down_out |-> !cmp_one_ladder_select_out && !cmp_two_ladder_select_out &&
			!pin_carries_ladder_out;
	endproperty
	a_ladder_power: assert property (p_ladder_power) else $error("ladder powered down in use");

	property p_pin_route;
		pin_carries_ladder_out |-> !pin_carries_fixed_out;
	endproperty
	a_pin_route: assert property (p_pin_route) else $error("pin carries both references");

	property p_stable_read;
		rd_in && addr_in == `CMPR_OFS_FIXED |=> rdata_out[`CMPR_FIX_STABLE_BIT] == $past(bandgap_stable_flag_in);
	endproperty
	a_stable_read: assert property (p_stable_read) else $error("stable flag misread");

	property p_mirror_no_refresh;
		rd_in && addr_in == `CMPR_OFS_MIRROR |-> !refresh_one && !refresh_two;
	endproperty
	a_mirror_no_refresh: assert property (p_mirror_no_refresh) else $error("mirror read refreshed");

	property p_hv_enable;
		HV_VARIANT == 1 |-> fixed_ref_enable_out;
	endproperty
	a_hv_enable: assert property (p_hv_enable) else $error("fixed reference not forced");

	property p_bypass;
		wr_in && addr_in == `CMPR_OFS_FIXED |=> pin_buffer_bypass_out == $past(wdata_in[`CMPR_FIX_BYPASS_BIT]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not written");

	sequence s_ladder_write;
		wr_in && addr_in == `CMPR_OFS_LADDER;
	endsequence

	property p_level_write;
		s_ladder_write |=> ladder_level_code_out == $past(wdata_in[3:0]) &&
			ladder_range_select_out == $past(wdata_in[`CMPR_LAD_RANGE_BIT]);
	endproperty
	a_level_write: assert property (p_level_write) else $error("level code not written");

	property p_ground_needs_zero;
		ladder_ground_out |-> ladder_power_down_out && ladder_range_select_out && ladder_level_code_out == 4'h0;
	endproperty
	a_ground_needs_zero: assert property (p_ground_needs_zero) else $error("ground with ladder in use");

	property p_select_write;
		s_ladder_write |=> cmp_one_ladder_select_out == $past(wdata_in[`CMPR_LAD_ONE_SEL_BIT]) &&
			cmp_two_ladder_select_out == $past(wdata_in[`CMPR_LAD_TWO_SEL_BIT]);
	endproperty
	a_select_write: assert property (p_select_write) else $error("ladder select not written");

	property p_off_reads_zero;
		!cmp_one_config_out[`CMPR_CTL_ON_BIT] |=> !cmp_one_latched;
	endproperty
	a_off_reads_zero: assert property (p_off_reads_zero) else $error("disabled comparator not zero");

	property p_output_latched;
		cmp_two_config_out[`CMPR_CTL_ON_BIT] |=>
			cmp_two_latched == ($past(cmp_two_raw_in) ^ $past(cmp_two_config_out[`CMPR_CTL_POL_BIT]));
	endproperty
	a_output_latched: assert property (p_output_latched) else $error("output not latched");

	property p_event_is_edge;
		cmp_one_set && !refresh_one |=> !cmp_one_set;
	endproperty
	a_event_is_edge: assert property (p_event_is_edge) else $error("event repeated on level");

	property p_flag_two_sets;
		cmp_two_set |=> cur.flags[`CMPR_FLAG_TWO_BIT];
	endproperty
	a_flag_two_sets: assert property (p_flag_two_sets) else $error("change did not set flag two");

	property p_fixed_write;
		wr_in && addr_in == `CMPR_OFS_FIXED && HV_VARIANT == 0 |=>
			fixed_ref_enable_out == $past(wdata_in[`CMPR_FIX_ENABLE_BIT]);
	endproperty
	a_fixed_write: assert property (p_fixed_write) else $error("fixed enable not written");

endmodule // cmpr_ctrl

`default_nettype wire

/* pkg/cmpr_cfg.svh */
// Register offsets, field positions and reset values of the comparator event and reference control block
`ifndef CMPR_CFG_SVH
`define CMPR_CFG_SVH

`define CMPR_ADDR_W 4
`define CMPR_DATA_W 8

`define CMPR_OFS_FLAGS 4'h0
`define CMPR_OFS_ENABLES 4'h1
`define CMPR_OFS_CMP_ONE 4'h2
`define CMPR_OFS_CMP_TWO 4'h3
`define CMPR_OFS_MIRROR 4'h4
`define CMPR_OFS_LADDER 4'h5
`define CMPR_OFS_FIXED 4'h6
`define CMPR_OFS_IRQ_CTL 4'h7

`define CMPR_FLAG_ONE_BIT 3
`define CMPR_FLAG_TWO_BIT 4

`define CMPR_CTL_ON_BIT 7
`define CMPR_CTL_OUT_BIT 6
`define CMPR_CTL_POL_BIT 4

`define CMPR_MIR_ONE_BIT 7
`define CMPR_MIR_TWO_BIT 6

`define CMPR_LAD_ONE_SEL_BIT 7
`define CMPR_LAD_TWO_SEL_BIT 6
`define CMPR_LAD_RANGE_BIT 5

`define CMPR_FIX_STABLE_BIT 5
`define CMPR_FIX_BYPASS_BIT 4
`define CMPR_FIX_ENABLE_BIT 3
`define CMPR_FIX_PIN_OE_BIT 2
`define CMPR_FIX_LADDER_OE_BIT 1

`define CMPR_IC_GLOBAL_BIT 7
`define CMPR_IC_PERIPH_BIT 6

`define CMPR_WMASK_CMP 8'hbf
`define CMPR_WMASK_MIRROR 8'h03
`define CMPR_WMASK_LADDER 8'hef
`define CMPR_WMASK_FIXED 8'h1e
`define CMPR_WMASK_IRQ_CTL 8'hc0

`define CMPR_RST_ZERO 8'h00
`define CMPR_RST_MIRROR 8'h02

`endif

/* pkg/cmpr_pkg.sv */
// Types shared by the comparator event and reference control block
`default_nettype none

package cmpr_pkg;

	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] enables;
		logic [7:0] cmp_one;
		logic [7:0] cmp_two;
		logic [7:0] mirror;
		logic [7:0] ladder;
		logic [7:0] fixed;
		logic [7:0] irq_ctl;
		logic [7:0] rdata;
	} cmpr_state_t;

	typedef struct packed {
		logic latched;
		logic ref_val;
		logic prev_mismatch;
	} cmpr_edge_t;

endpackage

`default_nettype wire

/* design/cmpr_edge_det.sv */
// Per-comparator output latch, mismatch latch and mismatch edge detector
`timescale 1ns/1ps
`default_nettype none

module cmpr_edge_det
	import cmpr_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Comparator side
	input wire logic cmp_output_in,
	input wire logic refresh_in,
	// Results
	output logic latched_out,
	output logic change_set_out
);

	cmpr_edge_t cur;
	cmpr_edge_t next_cur;
	logic mismatch;

	assign mismatch = cur.latched != cur.ref_val;
	// Edge, not level, so a cleared flag is not set again by a standing mismatch
	assign change_set_out = mismatch && !cur.prev_mismatch;
	assign latched_out = cur.latched;

	always_comb begin
		next_cur = cur;
		next_cur.latched = cmp_output_in;
		next_cur.prev_mismatch = mismatch;
		if (refresh_in) begin
			next_cur.ref_val = cur.latched;
			next_cur.prev_mismatch = 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	property p_event_needs_mismatch;
		change_set_out |-> cur.ref_val == $past(cur.latched);
	endproperty
	a_event_needs_mismatch: assert property (p_event_needs_mismatch) else $error("event without new mismatch");

	property p_refresh_takes_output;
		refresh_in |=> cur.ref_val == $past(cur.latched) && !change_set_out;
	endproperty
	a_refresh_takes_output: assert property (p_refresh_takes_output) else $error("refresh did not take output");

endmodule // cmpr_edge_det

`default_nettype wire

/* testbench/cmpr_analog_model.sv */
// Behavioural model of the two analog comparators and the bandgap reference
`timescale 1ns/1ps
`default_nettype none

module cmpr_analog_model #(
	parameter int SETTLE_CYCLES = 10
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Input condition per comparator: plus input above minus input
	input wire logic [1:0] vp_above_in,
	// Control from the block
	input wire logic fixed_ref_enable_in,
	// Results
	output logic cmp_one_raw_out,
	output logic cmp_two_raw_out,
	output logic bandgap_stable_out
);
	int settle_cnt;

	// Polarity and enable gating live in the block, so raw is the plain comparison
	assign cmp_one_raw_out = vp_above_in[0];
	assign cmp_two_raw_out = vp_above_in[1];

	// Bandgap is not trusted until it has settled after enable
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			settle_cnt <= 0;
		end else if (!fixed_ref_enable_in) begin
			settle_cnt <= 0;
		end else if (settle_cnt < SETTLE_CYCLES) begin
			settle_cnt <= settle_cnt + 1;
		end
	end
	assign bandgap_stable_out = fixed_ref_enable_in && (settle_cnt >= SETTLE_CYCLES);
endmodule // cmpr_analog_model

`default_nettype wire

/* testbench/cmpr_ctrl_tb.sv */
// Self-checking testbench of the comparator event and reference control block
`timescale 1ns/1ps
`default_nettype none

`include "cmpr_cfg.svh"

module cmpr_ctrl_tb;
	localparam logic [3:0] OF_FL = `CMPR_OFS_FLAGS;
	localparam logic [3:0] OF_EN = `CMPR_OFS_ENABLES;
	localparam logic [3:0] OF_MI = `CMPR_OFS_MIRROR;
	localparam logic [3:0] OF_LA = `CMPR_OFS_LADDER;
	localparam logic [3:0] OF_FX = `CMPR_OFS_FIXED;
	localparam logic [3:0] OF_IC = `CMPR_OFS_IRQ_CTL;
	logic clock_in, rst_b_in, wr, rd, irq, lrange, lsel1, lsel2, lpd, lgnd, fen, byp, pinl, pinf, raw1, raw2, bg;
	logic [3:0] addr, lcode;
	logic [7:0] wdata, rdata, v, cfg1, cfg2, mcfg;
	logic fen_hv;
	logic [1:0] vp;
	int failures, checks, cycles;

	cmpr_ctrl #(.HV_VARIANT(0)) cmpr_ctrl_i (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .cmp_one_raw_in(raw1),
		.cmp_two_raw_in(raw2), .bandgap_stable_flag_in(bg), .cmp_one_config_out(cfg1), .cmp_two_config_out(cfg2),
		.mirror_config_out(mcfg), .irq_out(irq), .ladder_level_code_out(lcode), .ladder_range_select_out(lrange),
		.cmp_one_ladder_select_out(lsel1), .cmp_two_ladder_select_out(lsel2), .ladder_power_down_out(lpd),
		.ladder_ground_out(lgnd), .fixed_ref_enable_out(fen), .pin_buffer_bypass_out(byp),
		.pin_carries_ladder_out(pinl), .pin_carries_fixed_out(pinf));

	// High-voltage variant on the same bus, watched only for its forced reference enable
	cmpr_ctrl #(.HV_VARIANT(1)) cmpr_ctrl_hv_i (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(), .cmp_one_raw_in(raw1), .cmp_two_raw_in(raw2),
		.bandgap_stable_flag_in(bg), .cmp_one_config_out(), .cmp_two_config_out(), .mirror_config_out(),
		.irq_out(), .ladder_level_code_out(), .ladder_range_select_out(), .cmp_one_ladder_select_out(),
		.cmp_two_ladder_select_out(), .ladder_power_down_out(), .ladder_ground_out(),
		.fixed_ref_enable_out(fen_hv), .pin_buffer_bypass_out(), .pin_carries_ladder_out(),
		.pin_carries_fixed_out());

	cmpr_analog_model #(.SETTLE_CYCLES(10)) cmpr_analog_model_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.vp_above_in(vp), .fixed_ref_enable_in(fen), .cmp_one_raw_out(raw1), .cmp_two_raw_out(raw2),
		.bandgap_stable_out(bg));

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock_in);
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_in);
		wr <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd_get(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_in);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp, input string name);
		logic [7:0] d;
		rd_get(a, d);
		chk(name, exp, d);
	endtask

	task automatic set_vp(input int k, input logic x);
		@(posedge clock_in);
		vp[k] <= x;
		wait_cyc(4);
	endtask

	task automatic check_reset();
		chk("reset outputs", 8'h04, {5'h0, lpd, lgnd, fen});
		chk("mirror config", `CMPR_RST_MIRROR, mcfg);
		chk("variant enable", 8'h01, {7'h0, fen_hv});
		for (int a = 0; a < 9; a++) begin
			reg_rd(4'(a), (a == 4) ? `CMPR_RST_MIRROR : `CMPR_RST_ZERO, "reset value");
		end
	endtask

	// Comparator two runs inverted, so its latched output is the complement of the input condition
	task automatic cmp_events(input int k);
		logic [3:0] ctl;
		logic [7:0] fl, pol, l1, m1;
		ctl = 4'h2 + 4'(k);
		fl = 8'h08 << k;
		pol = (k == 1) ? 8'h10 : 8'h00;
		l1 = (k == 0) ? 8'h40 : 8'h00;
		m1 = (k == 0) ? 8'h82 : 8'h02;
		set_vp(k, 1'b0);
		reg_wr(ctl, 8'h80 | pol);
		wait_cyc(25);
		reg_rd(ctl, 8'h80 | pol | (pol << 2), "control after enable");
		chk("config out", 8'h80 | pol | (pol << 2), (k == 0) ? cfg1 : cfg2);
		reg_wr(OF_FL, 8'h00);
		set_vp(k, 1'b1);
		reg_rd(OF_FL, fl, "flag on change");
		chk("irq while masked", 8'h00, {7'h0, irq});
		reg_wr(OF_FL, 8'h00);
		wait_cyc(3);
		reg_rd(OF_FL, 8'h00, "flag after clear");
		reg_rd(OF_MI, m1, "mirror");
		set_vp(k, 1'b0);
		reg_rd(OF_FL, 8'h00, "return without refresh");
		set_vp(k, 1'b1);
		reg_rd(OF_FL, fl, "second change");
		reg_wr(OF_FL, 8'h00);
		reg_rd(ctl, 8'h80 | pol | l1, "control refresh");
		set_vp(k, 1'b0);
		reg_rd(OF_FL, fl, "return after refresh");
		reg_wr(OF_FL, 8'h00);
		reg_wr(OF_FL, fl);
		reg_rd(OF_FL, fl, "flag written one");
		for (int i = 0; i < 8; i++) begin
			reg_wr(OF_EN, i[0] ? fl : 8'h00);
			reg_wr(OF_IC, {i[2], i[1], 6'h00});
			chk("irq gate", {7'h0, i == 7}, {7'h0, irq});
		end
		reg_wr(OF_IC, 8'h00);
		reg_wr(OF_EN, 8'h00);
		reg_wr(ctl, 8'h00);
		$display("comparator %0d events done", k);
	endtask

	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			$display("[ERR] run length expected below 5000 seen %0d", cycles);
			stop_test();
		end
	end

	initial begin
		rst_b_in = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		vp = 2'b00;
		failures = 0;
		checks = 0;
		cycles = 0;
		wait_cyc(6);
		rst_b_in <= 1'b1;
		wait_cyc(1);
		check_reset();
		$display("reset values done");
		cmp_events(0);
		cmp_events(1);
		reg_wr(OF_LA, 8'hff);
		reg_rd(OF_LA, 8'hef, "ladder readback");
		chk("level code", 8'h0f, {4'h0, lcode});
		chk("ladder selects", 8'h07, {5'h0, lrange, lsel1, lsel2});
		chk("ladder power", 8'h00, {6'h0, lpd, lgnd});
		reg_wr(OF_LA, 8'h20);
		chk("ladder ground", 8'h03, {6'h0, lpd, lgnd});
		reg_wr(OF_LA, 8'h00);
		chk("high range off", 8'h02, {6'h0, lpd, lgnd});
		reg_wr(OF_LA, 8'h40);
		chk("second select", 8'h01, {5'h0, lrange, lsel1, lsel2});
		chk("second powers", 8'h00, {7'h0, lpd});
		reg_wr(OF_LA, 8'h00);
		reg_rd(OF_FX, 8'h00, "fixed idle");
		reg_wr(OF_FX, 8'h08);
		v = 8'h00;
		for (int i = 0; i < 40 && !v[5]; i++) begin
			rd_get(OF_FX, v);
		end
		chk("bandgap stable", 8'h28, v);
		reg_wr(OF_FX, 8'hff);
		reg_rd(OF_FX, 8'h3e, "fixed readback");
		chk("routing all set", 8'h0e, {4'h0, byp, fen, pinl, pinf});
		reg_wr(OF_FX, 8'h02);
		chk("ladder pin powers", 8'h00, {7'h0, lpd});
		chk("routing ladder", 8'h02, {4'h0, byp, fen, pinl, pinf});
		reg_wr(OF_FX, 8'h04);
		chk("routing fixed", 8'h01, {4'h0, byp, fen, pinl, pinf});
		reg_wr(OF_MI, 8'hff);
		reg_rd(OF_MI, 8'h03, "mirror writable bits");
		chk("mirror config written", 8'h03, mcfg);
		$display("references done");
		reg_wr(OF_LA, 8'hcf);
		reg_wr(OF_FL, 8'h18);
		@(posedge clock_in);
		rst_b_in <= 1'b0;
		wait_cyc(3);
		rst_b_in <= 1'b1;
		wait_cyc(1);
		check_reset();
		$display("second reset done");
		stop_test();
	end
endmodule // cmpr_ctrl_tb

`default_nettype wire
